//--- dda_pkg.sv
// Purpose: Shared constants, types and helpers for the incremental arithmetic modules
// Assumes: Increments are 2-bit {sign, magnitude}; sign high means negative
// Notes:   Fractions are Q1.15; remainders use a doubled scale so that half a step is exact
package dda_pkg;
  localparam int unsigned DDA_W = 16;

  // Word offsets on the register bus
  localparam logic [7:0] DDA_CTRL_OFS   = 8'h00;
  localparam logic [7:0] DDA_STAT_OFS   = 8'h04;
  localparam logic [7:0] DDA_IC_INT_OFS = 8'h08;
  localparam logic [7:0] DDA_CM_Y_OFS   = 8'h0C;
  localparam logic [7:0] DDA_IC_VX_OFS  = 8'h10;
  localparam logic [7:0] DDA_IC_VY_OFS  = 8'h14;
  localparam logic [7:0] DDA_IC_DEC_OFS = 8'h18;
  localparam logic [7:0] DDA_INT_Y_OFS  = 8'h1C;
  localparam logic [7:0] DDA_VM_X_OFS   = 8'h20;
  localparam logic [7:0] DDA_VM_Y_OFS   = 8'h24;
  localparam logic [7:0] DDA_DS_Y_OFS   = 8'h28;
  localparam logic [7:0] DDA_DEC_Y_OFS  = 8'h2C;
  localparam logic [7:0] DDA_INT_R_OFS  = 8'h30;

  // Control field positions
  localparam int unsigned DDA_CTRL_HALT_BIT = 0;
  localparam int unsigned DDA_CTRL_SUM_BIT  = 1;
  localparam int unsigned DDA_CTRL_SHIFT_LO = 4;

  // Status bit positions
  localparam int unsigned DDA_ST_INT_Y = 0;
  localparam int unsigned DDA_ST_VM_X  = 1;
  localparam int unsigned DDA_ST_VM_Y  = 2;
  localparam int unsigned DDA_ST_VM_S  = 3;

  // Reset values
  localparam logic [2:0]  DDA_SHIFT_RST = 3'h0;
  localparam logic [15:0] DDA_IC_RST    = 16'h0000;

  // Fixed-point limits, integrand scale (Q1.15) widened to 18 bits
  localparam logic signed [17:0] DDA_Y_MAX = 18'sh0_7FFF;
  localparam logic signed [17:0] DDA_Y_MIN = -18'sh0_8000;
  localparam logic signed [17:0] DDA_Y_HALF = 18'sh0_4000;
  // Remainder and addend use doubled scale: 1.0 is 2^16
  localparam logic signed [20:0] DDA_R_ONE  = 21'sh01_0000;
  localparam logic [15:0]        DDA_R_HALF = 16'h8000;

  typedef logic [1:0] dda_inc_t;

  function automatic logic signed [2:0] dda_tern(input dda_inc_t inc);
    dda_tern = inc[0] ? (inc[1] ? -3'sd1 : 3'sd1) : 3'sd0;
  endfunction

  function automatic logic dda_oor(input logic signed [17:0] v);
    dda_oor = (v > DDA_Y_MAX) || (v < DDA_Y_MIN);
  endfunction

  function automatic logic [15:0] dda_wr16(input logic [15:0] old, input logic [31:0] dat,
                                            input logic [3:0] sel);
    dda_wr16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
  endfunction
endpackage

//--- dda_acc_if.sv
// Purpose: Carries addend and output increment between a unit and its remainder stage
// Assumes: Addend is in doubled scale, within one unit either side of zero
// Notes:   owner drives step, load and addend; stage answers with output and remainder
`timescale 1ns/1ps
interface dda_acc_if;
  import dda_pkg::*;
  logic               step;
  logic               load;
  logic signed [19:0] addend;
  dda_inc_t           dz;
  logic [15:0]        rem;
  modport owner (output step, output load, output addend, input dz, input rem);
  modport stage (input step, input load, input addend, output dz, output rem);
endinterface

//--- dda_rem_stage.sv
// Purpose: Remainder register with overflow into a signed output increment
// Assumes: Addend stays within plus or minus one unit per cycle
// Notes:   One output circuit per remainder, instanced once by each accumulating unit
`timescale 1ns/1ps
module dda_rem_stage
  import dda_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  dda_acc_if.stage  acc
);
  typedef struct packed {
    logic [15:0] rem;
    dda_inc_t    dz;
  } dda_rs_t;

  dda_rs_t st_ff;
  dda_rs_t nxt_st;
  logic signed [20:0] sum;

  assign acc.dz  = st_ff.dz;
  assign acc.rem = st_ff.rem;

  always_comb begin
    nxt_st = st_ff;
    sum = $signed({5'h00, st_ff.rem}) + 21'(acc.addend);
    if (acc.load) begin
      nxt_st.rem = DDA_R_HALF;
      nxt_st.dz  = 2'b00;
    end else if (acc.step) begin
      nxt_st.dz[1] = acc.addend < 0;
      if (sum >= DDA_R_ONE) begin
        nxt_st.dz[0] = 1'b1;
        nxt_st.rem = 16'(sum - DDA_R_ONE);
      end else if (sum < 0) begin
        nxt_st.dz[0] = 1'b1;
        nxt_st.rem = 16'(sum + DDA_R_ONE);
      end else begin
        nxt_st.dz[0] = 1'b0;
        nxt_st.rem = 16'(sum);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '{rem: DDA_R_HALF, dz: 2'b00};
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule

//--- dda_top.sv
// Function
// - Integrand holds signed fraction reaching -1 but never +1.
// - Integrator adds ((Y plus dY) times |dX| plus half dY) signed by dX.
// - Primary increment is magnitude bit plus sign bit: +1, 0 or -1.
// - Remember last nonzero primary sign and use it when increment is zero.
// - Remainder lies in 0 to 1 and starts at one half.
// - Output increment sign equals sign of this cycle's addend.
// - Remainder plus addend at least 1 gives +1 and keeps fraction.
// - Remainder plus addend below 0 gives -1 and keeps wrapped remainder.
// - Remainder plus addend in 0 up to 1 gives no output.
// - Constant multiplier is an integrator without secondary inputs, fixed integrand.
// - Variable multiplier adds old X times dY plus new Y times dX.
// - Variable multiplier holds X, Y, their two initial values, one remainder.
// - Variable multiplier flags X, Y or addend leaving -1 to +1.
// - Digital servo sums two secondary inputs, outputs when 0 < |Y| < 1.
// - Servo output sign is primary sign times integrand sign, no remainder.
// - Global reset clears digital servo integrand.
// - Decision servo outputs for Y in (0, 1/2) or [-1/2, 0).
// - Global reset reloads decision servo integrand from its initial value.
// - At most two direct secondary inputs; more come via the summer.
// - Summer phase one forms two partial sums of three, each -3 to +3.
// - Summer phase two adds partials, -6 to +6, shifted into integrator and servo.
// - Global reset copies initial-condition registers into computing registers.
// - Each output increment is a sign line and an existence line.
// - Integrand beyond full scale raises overflow, optionally halting computation; the servo integrands here wrap without raising it.
//
// Purpose: Integrator, constant and variable multipliers, two servos and a six-input summer
// Assumes: step_i is a one-cycle strobe from the timing unit; inputs are synchronous
// Notes:   Registers over classic Wishbone, one aligned 32-bit word each
//
// The implementer's own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
module dda_top
  import dda_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        step_i,
  input  wire logic        run_reset_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire dda_inc_t    int_dx_i,
  input  wire dda_inc_t    int_dy1_i,
  input  wire dda_inc_t    int_dy2_i,
  input  wire dda_inc_t    cm_dx_i,
  input  wire dda_inc_t    vm_dx_i,
  input  wire dda_inc_t    vm_dy_i,
  input  wire dda_inc_t    ds_dx_i,
  input  wire dda_inc_t    ds_dy1_i,
  input  wire dda_inc_t    ds_dy2_i,
  input  wire dda_inc_t    dec_dx_i,
  input  wire dda_inc_t    dec_dy1_i,
  input  wire dda_inc_t    dec_dy2_i,
  input  wire logic [11:0] sum_dy_i,
  output dda_inc_t         int_dz_o,
  output dda_inc_t         cm_dz_o,
  output dda_inc_t         vm_dz_o,
  output dda_inc_t         ds_dz_o,
  output dda_inc_t         dec_dz_o,
  output logic             ovf_o
);
  typedef struct packed {
    logic              halt_en;
    logic              sum_en;
    logic [2:0]        shift;
    logic [3:0]        stat;
    logic              ack;
    logic [31:0]       rdat;
    logic [15:0]       ic_int;
    logic [15:0]       cm_y;
    logic [15:0]       ic_vx;
    logic [15:0]       ic_vy;
    logic [15:0]       ic_dec;
    logic signed [15:0] int_y;
    logic signed [15:0] vm_x;
    logic signed [15:0] vm_y;
    logic signed [15:0] ds_y;
    logic signed [15:0] dec_y;
    logic              int_ls;
    logic              cm_ls;
    logic signed [2:0] part1;
    logic signed [2:0] part2;
    logic signed [3:0] fin;
    logic              ph2;
    dda_inc_t          ds_dz;
    dda_inc_t          dec_dz;
    logic              ovf;
  } dda_top_t;

  dda_top_t st_ff;
  dda_top_t nxt_st;

  dda_acc_if int_acc ();
  dda_acc_if cm_acc ();
  dda_acc_if vm_acc ();

  dda_rem_stage u_int_rem (.clk_i(clk_i), .rst_i(rst_i), .acc(int_acc));
  dda_rem_stage u_cm_rem  (.clk_i(clk_i), .rst_i(rst_i), .acc(cm_acc));
  dda_rem_stage u_vm_rem  (.clk_i(clk_i), .rst_i(rst_i), .acc(vm_acc));

  assign wb_dat_o = st_ff.rdat;
  assign wb_ack_o = st_ff.ack;
  assign int_dz_o = int_acc.dz;
  assign cm_dz_o  = cm_acc.dz;
  assign vm_dz_o  = vm_acc.dz;
  assign ds_dz_o  = st_ff.ds_dz;
  assign dec_dz_o = st_ff.dec_dz;
  assign ovf_o    = st_ff.ovf;

  always_comb begin
    logic               run;
    logic               wr;
    logic               rd;
    logic signed [4:0]  shift_in;
    logic signed [4:0]  int_dyt;
    logic signed [4:0]  ds_dyt;
    logic signed [4:0]  dec_dyt;
    logic signed [17:0] int_d;
    logic signed [17:0] int_yn;
    logic signed [19:0] base;
    logic               sgn;
    logic signed [17:0] vx_n;
    logic signed [17:0] vy_n;
    logic signed [19:0] vm_s;
    logic signed [17:0] ds_n;
    logic signed [17:0] dec_n;
    logic [3:0]         ev;
    run = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    shift_in = 5'sd0;
    int_dyt = 5'sd0;
    ds_dyt = 5'sd0;
    dec_dyt = 5'sd0;
    int_d = 18'sd0;
    int_yn = 18'sd0;
    base = 20'sd0;
    sgn = 1'b0;
    vx_n = 18'sd0;
    vy_n = 18'sd0;
    vm_s = 20'sd0;
    ds_n = 18'sd0;
    dec_n = 18'sd0;
    ev = 4'h0;
    nxt_st = st_ff;

    // Halting freezes every unit together so chains stay consistent
    run = step_i && !(st_ff.halt_en && (|st_ff.stat)) && !run_reset_i;

    // Summer: phase one latches partials, phase two forms the final sum
    if (run) begin
      nxt_st.part1 = 3'(dda_tern(sum_dy_i[1:0]) + dda_tern(sum_dy_i[3:2])
                     + dda_tern(sum_dy_i[5:4]));
      nxt_st.part2 = 3'(dda_tern(sum_dy_i[7:6]) + dda_tern(sum_dy_i[9:8])
                     + dda_tern(sum_dy_i[11:10]));
    end
    nxt_st.ph2 = run;
    if (st_ff.ph2) begin
      nxt_st.fin = 4'(st_ff.part1) + 4'(st_ff.part2);
    end
    // The summer enable gates the final sum into the integrator and the digital servo
    shift_in = st_ff.sum_en ? 5'(st_ff.fin) : 5'sd0;

    // Two direct secondary inputs per unit, widened by the summer only
    int_dyt = 5'(dda_tern(int_dy1_i)) + 5'(dda_tern(int_dy2_i)) + shift_in;
    ds_dyt  = 5'(dda_tern(ds_dy1_i)) + 5'(dda_tern(ds_dy2_i)) + shift_in;
    dec_dyt = 5'(dda_tern(dec_dy1_i)) + 5'(dda_tern(dec_dy2_i));

    // Integrator: trapezoidal extrapolative addend in doubled scale
    int_d  = 18'(int_dyt) <<< st_ff.shift;
    int_yn = 18'(st_ff.int_y) + int_d;
    sgn    = int_dx_i[0] ? int_dx_i[1] : st_ff.int_ls;
    base   = (int_dx_i[0] ? 20'(int_yn) <<< 1 : 20'sd0) + 20'(int_d);
    int_acc.addend = sgn ? -base : base;
    int_acc.step   = run;
    int_acc.load   = run_reset_i;
    ev[DDA_ST_INT_Y] = run && dda_oor(int_yn);

    // Constant multiplier: same path, integrand never incremented
    sgn  = cm_dx_i[0] ? cm_dx_i[1] : st_ff.cm_ls;
    base = cm_dx_i[0] ? 20'($signed(st_ff.cm_y)) <<< 1 : 20'sd0;
    cm_acc.addend = sgn ? -base : base;
    cm_acc.step   = run;
    cm_acc.load   = run_reset_i;

    // Variable multiplier: old X by dY plus new Y by dX, one remainder
    vx_n = 18'(st_ff.vm_x) + (18'(dda_tern(vm_dx_i)) <<< st_ff.shift);
    vy_n = 18'(st_ff.vm_y) + (18'(dda_tern(vm_dy_i)) <<< st_ff.shift);
    vm_s = 20'(dda_tern(vm_dy_i)) * 20'(st_ff.vm_x)
         + 20'(dda_tern(vm_dx_i)) * 20'(vy_n);
    vm_acc.addend = vm_s <<< 1;
    vm_acc.step   = run;
    vm_acc.load   = run_reset_i;
    ev[DDA_ST_VM_X] = run && dda_oor(vx_n);
    ev[DDA_ST_VM_Y] = run && dda_oor(vy_n);
    ev[DDA_ST_VM_S] = run && dda_oor(18'(vm_s));

    ds_n  = 18'(st_ff.ds_y) + (18'(ds_dyt) <<< st_ff.shift);
    dec_n = 18'(st_ff.dec_y) + (18'(dec_dyt) <<< st_ff.shift);

    if (run_reset_i) begin
      nxt_st.int_y  = st_ff.ic_int;
      nxt_st.vm_x   = st_ff.ic_vx;
      nxt_st.vm_y   = st_ff.ic_vy;
      nxt_st.ds_y   = 16'sh0000;
      nxt_st.dec_y  = st_ff.ic_dec;
      nxt_st.ds_dz  = 2'b00;
      nxt_st.dec_dz = 2'b00;
      nxt_st.fin    = 4'sd0;
    end else if (run) begin
      // Wrap within the word; integrator and multiplier excursions are reported, servo ones are not, none clamped
      nxt_st.int_y = int_yn[15:0];
      nxt_st.vm_x  = vx_n[15:0];
      nxt_st.vm_y  = vy_n[15:0];
      nxt_st.ds_y  = ds_n[15:0];
      nxt_st.dec_y = dec_n[15:0];
      if (int_dx_i[0]) nxt_st.int_ls = int_dx_i[1];
      if (cm_dx_i[0]) nxt_st.cm_ls = cm_dx_i[1];
      // Servos act on the integrand held at the start of the cycle
      nxt_st.ds_dz[0] = ds_dx_i[0] && (st_ff.ds_y != 16'sh0000)
                        && (st_ff.ds_y != 16'sh8000);
      nxt_st.ds_dz[1] = ds_dx_i[1] ^ st_ff.ds_y[15];
      nxt_st.dec_dz[0] = dec_dx_i[0]
        && ((18'(st_ff.dec_y) > 18'sd0 && 18'(st_ff.dec_y) < DDA_Y_HALF)
         || (18'(st_ff.dec_y) < 18'sd0 && 18'(st_ff.dec_y) >= -DDA_Y_HALF));
      nxt_st.dec_dz[1] = dec_dx_i[1] ^ st_ff.dec_y[15];
    end

    // Wishbone classic slave, one wait state, ack drops after one cycle
    wr = wb_cyc_i && wb_stb_i && wb_we_i && !st_ff.ack;
    rd = wb_cyc_i && wb_stb_i && !wb_we_i && !st_ff.ack;
    nxt_st.ack  = wb_cyc_i && wb_stb_i && !st_ff.ack;
    nxt_st.rdat = 32'h0000_0000;
    if (wr) begin
      if (wb_adr_i == DDA_CTRL_OFS) begin
        if (wb_sel_i[0]) begin
          nxt_st.halt_en = wb_dat_i[DDA_CTRL_HALT_BIT];
          nxt_st.sum_en  = wb_dat_i[DDA_CTRL_SUM_BIT];
          nxt_st.shift   = wb_dat_i[DDA_CTRL_SHIFT_LO +: 3];
        end
      end else if (wb_adr_i == DDA_STAT_OFS) begin
        if (wb_sel_i[0]) nxt_st.stat = st_ff.stat & ~wb_dat_i[3:0];
      end else if (wb_adr_i == DDA_IC_INT_OFS) begin
        nxt_st.ic_int = dda_wr16(st_ff.ic_int, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == DDA_CM_Y_OFS) begin
        nxt_st.cm_y = dda_wr16(st_ff.cm_y, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == DDA_IC_VX_OFS) begin
        nxt_st.ic_vx = dda_wr16(st_ff.ic_vx, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == DDA_IC_VY_OFS) begin
        nxt_st.ic_vy = dda_wr16(st_ff.ic_vy, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == DDA_IC_DEC_OFS) begin
        nxt_st.ic_dec = dda_wr16(st_ff.ic_dec, wb_dat_i, wb_sel_i);
      end
    end
    // Sticky overflow: a new event wins over a clear in the same cycle
    nxt_st.stat = nxt_st.stat | ev;
    // Registered copy keeps the pin glitch free and in step with status
    nxt_st.ovf  = |nxt_st.stat;
    if (rd) begin
      if (wb_adr_i == DDA_CTRL_OFS) begin
        nxt_st.rdat = {24'h00_0000, 1'b0, st_ff.shift, 2'b00, st_ff.sum_en, st_ff.halt_en};
      end else if (wb_adr_i == DDA_STAT_OFS) begin
        nxt_st.rdat = {28'h000_0000, st_ff.stat};
      end else if (wb_adr_i == DDA_IC_INT_OFS) begin
        nxt_st.rdat = {16'h0000, st_ff.ic_int};
      end else if (wb_adr_i == DDA_CM_Y_OFS) begin
        nxt_st.rdat = {16'h0000, st_ff.cm_y};
      end else if (wb_adr_i == DDA_IC_VX_OFS) begin
        nxt_st.rdat = {16'h0000, st_ff.ic_vx};
      end else if (wb_adr_i == DDA_IC_VY_OFS) begin
        nxt_st.rdat = {16'h0000, st_ff.ic_vy};
      end else if (wb_adr_i == DDA_IC_DEC_OFS) begin
        nxt_st.rdat = {16'h0000, st_ff.ic_dec};
      end else if (wb_adr_i == DDA_INT_Y_OFS) begin
        nxt_st.rdat = {16'h0000, st_ff.int_y};
      end else if (wb_adr_i == DDA_VM_X_OFS) begin
        nxt_st.rdat = {16'h0000, st_ff.vm_x};
      end else if (wb_adr_i == DDA_VM_Y_OFS) begin
        nxt_st.rdat = {16'h0000, st_ff.vm_y};
      end else if (wb_adr_i == DDA_DS_Y_OFS) begin
        nxt_st.rdat = {16'h0000, st_ff.ds_y};
      end else if (wb_adr_i == DDA_DEC_Y_OFS) begin
        nxt_st.rdat = {16'h0000, st_ff.dec_y};
      end else if (wb_adr_i == DDA_INT_R_OFS) begin
        nxt_st.rdat = {16'h0000, int_acc.rem};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
      st_ff.shift  <= DDA_SHIFT_RST;
      st_ff.ic_int <= DDA_IC_RST;
      st_ff.cm_y   <= DDA_IC_RST;
      st_ff.ic_vx  <= DDA_IC_RST;
      st_ff.ic_vy  <= DDA_IC_RST;
      st_ff.ic_dec <= DDA_IC_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule

//--- dda_chk_properties.sv
// Purpose: Port-level checks for the incremental arithmetic block
// Assumes: Sees top-level ports only; one clock, synchronous reset
// Notes:   Halted steps may leave outputs unchanged, so idle checks allow a hold
`timescale 1ns/1ps
module dda_chk
  import dda_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        step_i,
  input wire logic        run_reset_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire dda_inc_t    cm_dx_i,
  input wire dda_inc_t    vm_dx_i,
  input wire dda_inc_t    vm_dy_i,
  input wire dda_inc_t    ds_dx_i,
  input wire dda_inc_t    dec_dx_i,
  input wire dda_inc_t    int_dz_o,
  input wire dda_inc_t    cm_dz_o,
  input wire dda_inc_t    vm_dz_o,
  input wire dda_inc_t    ds_dz_o,
  input wire dda_inc_t    dec_dz_o,
  input wire logic        ovf_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_wait_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not given one cycle after request");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero outside ack");
  run_clear_a: assert property (run_reset_i |=> {int_dz_o, cm_dz_o, vm_dz_o, ds_dz_o,
    dec_dz_o} == 10'h000) else $error("outputs not cleared by run reset");
  out_hold_a: assert property (!step_i && !run_reset_i |=>
    $stable({int_dz_o, cm_dz_o, vm_dz_o, ds_dz_o, dec_dz_o})) else $error("output moved without step");
  servo_idle_a: assert property (step_i && !run_reset_i && !ds_dx_i[0] |=>
    !ds_dz_o[0] || $stable(ds_dz_o)) else $error("servo output without primary");
  dec_idle_a: assert property (step_i && !run_reset_i && !dec_dx_i[0] |=>
    !dec_dz_o[0] || $stable(dec_dz_o)) else $error("decision output without primary");
  cm_idle_a: assert property (step_i && !run_reset_i && !cm_dx_i[0] |=>
    !cm_dz_o[0] || $stable(cm_dz_o)) else $error("constant output without primary");
  vm_idle_a: assert property (step_i && !run_reset_i && !vm_dx_i[0] && !vm_dy_i[0] |=>
    !vm_dz_o[0] || $stable(vm_dz_o)) else $error("product output without inputs");
  rst_clear_a: assert property (disable iff (1'b0) rst_i |=> !ovf_o && !wb_ack_o &&
    {int_dz_o, cm_dz_o, vm_dz_o, ds_dz_o, dec_dz_o} == 10'h000) else $error("reset left outputs set");
endmodule

bind dda_top dda_chk chk (.clk_i, .rst_i, .step_i, .run_reset_i, .wb_cyc_i, .wb_stb_i,
  .wb_dat_o, .wb_ack_o, .cm_dx_i, .vm_dx_i, .vm_dy_i, .ds_dx_i, .dec_dx_i, .int_dz_o,
  .cm_dz_o, .vm_dz_o, .ds_dz_o, .dec_dz_o, .ovf_o);

//--- dda_patch_src.sv
// Purpose: Upstream patched modules feeding ternary increments, one lane each
// Assumes: Lane is {sign, exists}; loaded one cycle before the step that uses it
// Notes:   Idle lanes flip their sign so a stale sign is never trusted
`timescale 1ns/1ps
module dda_patch_src #(
  parameter int N = 18
) (
  input  wire logic           clk_i,
  input  wire logic           load_i,
  input  wire logic [2*N-1:0] val_i,
  output logic      [2*N-1:0] inc_o
);
  initial inc_o = '0;
  always @(posedge clk_i) begin
    if (load_i) begin
      for (int k = 0; k < N; k++) begin
        inc_o[2*k]   <= val_i[2*k];
        inc_o[2*k+1] <= val_i[2*k] ? val_i[2*k+1] : ~inc_o[2*k+1];
      end
    end
  end
endmodule

//--- dda_incremental_modules_tb.sv
// Purpose: Self-checking bench with a reference model of every unit
// Assumes: Scale shift 0 and summer disconnected except in one run, values inside range until the overflow test
// Notes:   Steps every third cycle so the patch source can load first
`timescale 1ns/1ps
module dda_incremental_modules_tb;
  import dda_pkg::*;
  logic        clk_i = 0, rst_i = 1, step_i = 0, run_reset_i = 0, load = 0, chk_dz = 0;
  logic        wb_cyc = 0, wb_stb = 0, wb_we = 0, wb_ack_o, ovf_o, isg, csg, halt = 0, first;
  logic [7:0]  wb_adr = '0;
  logic [3:0]  wb_sel = '0, stat = '0;
  logic [31:0] wb_dat = '0, wb_dat_o, rd_q[$];
  logic [35:0] val = '0, inc;
  logic [9:0]  dz_q[$], last;
  dda_inc_t    int_dz, cm_dz, vm_dz, ds_dz, dec_dz, x[12];
  int          mismatches = 0, num_checks = 0, seed = 32'heda2_901b;
  int          iy, cy, vx, vy, sy, ey, ir, cr, vr, icv[5], sf, sc = 1, son = 0;
  int          dec_ic[6] = '{16383, 16384, -16384, -16385, 0, -1};
  logic [7:0]  ico[5] = '{DDA_IC_INT_OFS, DDA_CM_Y_OFS, DDA_IC_VX_OFS, DDA_IC_VY_OFS, DDA_IC_DEC_OFS};
  logic [7:0]  roo[6] = '{DDA_INT_Y_OFS, DDA_VM_X_OFS, DDA_VM_Y_OFS, DDA_DS_Y_OFS, DDA_DEC_Y_OFS,
                          DDA_INT_R_OFS};

  always #50 clk_i = ~clk_i;

  dda_patch_src #(.N(18)) src (.clk_i(clk_i), .load_i(load), .val_i(val), .inc_o(inc));
  dda_top uut (.clk_i(clk_i), .rst_i(rst_i), .step_i(step_i), .run_reset_i(run_reset_i),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .int_dx_i(inc[1:0]),
    .int_dy1_i(inc[3:2]), .int_dy2_i(inc[5:4]), .cm_dx_i(inc[7:6]), .vm_dx_i(inc[9:8]),
    .vm_dy_i(inc[11:10]), .ds_dx_i(inc[13:12]), .ds_dy1_i(inc[15:14]), .ds_dy2_i(inc[17:16]),
    .dec_dx_i(inc[19:18]), .dec_dy1_i(inc[21:20]), .dec_dy2_i(inc[23:22]),
    .sum_dy_i(inc[35:24]), .int_dz_o(int_dz), .cm_dz_o(cm_dz), .vm_dz_o(vm_dz),
    .ds_dz_o(ds_dz), .dec_dz_o(dec_dz), .ovf_o(ovf_o));

  function automatic int t3(input logic [1:0] v);
    return v[0] ? (v[1] ? -1 : 1) : 0;
  endfunction
  function automatic int w16(input int v);
    logic signed [15:0] t;
    t = v[15:0];
    return t;
  endfunction
  // Sign is meaningless when no increment exists
  function automatic logic [9:0] nz(input logic [9:0] v);
    for (int k = 0; k < 5; k++) v[2*k+1] = v[2*k+1] & v[2*k];
    return v;
  endfunction

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input int d, input logic [3:0] s);
    @(posedge clk_i);
    {wb_cyc, wb_stb, wb_we} <= {2'b11, we};
    {wb_adr, wb_dat, wb_sel} <= {a, 32'(d), s};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    {wb_cyc, wb_stb} <= 2'b00;
  endtask

  task automatic rd(input logic [7:0] a, input int e);
    rd_q.push_back({16'h0000, 16'(e)});
    wb(1'b0, a, 0, 4'hf);
  endtask

  // Remainder stage: overflow either way leaves the wrapped fraction
  task automatic acc(inout int r, input int s, output logic [1:0] z);
    r += s;
    z = (r >= 65536 || r < 0) ? {s < 0, 1'b1} : 2'b00;
    if (r >= 65536) r -= 65536;
    if (r < 0) r += 65536;
  endtask

  task automatic rerun();
    @(posedge clk_i);
    run_reset_i <= 1'b1;
    @(posedge clk_i);
    run_reset_i <= 1'b0;
    {iy, cy, vx, vy, ey} = {icv[0], icv[1], icv[2], icv[3], icv[4]};
    {sy, sf} = {32'sd0, 32'sd0};
    {ir, cr, vr} = {3{32'sd32768}};
    {last, first} = {10'h000, 1'b1};
    dz_q.push_back(10'h000);
  endtask

  task automatic step(input int mode);
    logic [35:0] v;
    int d;
    logic [1:0] zi, zc, zv, zs, ze;
    v = {4'($random(seed)), 32'($random(seed))};
    // Remembered signs are unknown after a run reset, so set them first
    if (first) {v[1:0], v[5:2], v[7:6], v[9:8], v[13:12], v[19:18]} = 14'b01_0000_01_01_01_01;
    if (mode == 1) v[5:0] = 6'b00_01_00;
    @(posedge clk_i);
    {val, load} <= {v, 1'b1};
    @(posedge clk_i);
    {load, step_i} <= 2'b01;
    @(posedge clk_i);
    step_i <= 1'b0;
    if (halt && stat != 0) begin
      dz_q.push_back(last);
      return;
    end
    first = 0;
    for (int k = 0; k < 12; k++) x[k] = inc[2*k +: 2];
    d = (t3(x[1]) + t3(x[2]) + son * sf) * sc;
    if (x[0][0]) isg = x[0][1];
    acc(ir, ((x[0][0] ? (iy + d) * 2 : 0) + d) * (isg ? -1 : 1), zi);
    if (iy + d > 32767 || iy + d < -32768) stat[0] = 1'b1;
    iy = w16(iy + d);
    if (x[3][0]) csg = x[3][1];
    acc(cr, (x[3][0] ? cy * 2 : 0) * (csg ? -1 : 1), zc);
    vy += t3(x[5]) * sc;
    acc(vr, 2 * (t3(x[5]) * vx + t3(x[4]) * vy), zv);
    vx += t3(x[4]) * sc;
    zs = (x[6][0] && sy != 0 && sy != -32768) ? {x[6][1] ^ (sy < 0), 1'b1} : 2'b00;
    sy += (t3(x[7]) + t3(x[8]) + son * sf) * sc;
    ze = (x[9][0] && ((ey > 0 && ey < 16384) || (ey < 0 && ey >= -16384))) ?
         {x[9][1] ^ (ey < 0), 1'b1} : 2'b00;
    ey += (t3(x[10]) + t3(x[11])) * sc;
    // Summer result enters the integrand one step later
    sf = 0;
    for (int k = 12; k < 18; k++) sf += t3(inc[2*k +: 2]);
    last = {zi, zc, zv, zs, ze};
    dz_q.push_back(last);
  endtask

  always @(posedge clk_i) begin
    if (chk_dz) chk("increments", 32'(nz({int_dz, cm_dz, vm_dz, ds_dz, dec_dz})),
                    32'(dz_q.pop_front()));
    if (wb_ack_o === 1'b1 && wb_we === 1'b0) chk("read", wb_dat_o, rd_q.pop_front());
    chk_dz <= (step_i || run_reset_i) && !rst_i;
  end

  initial begin
    #2_000_000;
    mismatches++;
    close_out();
  end

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(DDA_CTRL_OFS, 0);
    rd(DDA_IC_INT_OFS, DDA_IC_RST);
    rd(8'h34, 0);
    wb(1'b1, DDA_IC_INT_OFS, 32'hffff_abcd, 4'h1);
    rd(DDA_IC_INT_OFS, 32'h0000_00cd);
    wb(1'b1, DDA_INT_Y_OFS, 32'h0000_1234, 4'hf);
    rd(DDA_INT_Y_OFS, 0);
    rd(DDA_INT_R_OFS, 32'h0000_8000);
    foreach (dec_ic[n]) begin
      for (int k = 0; k < 4; k++) icv[k] = $random(seed) % 4096;
      icv[4] = dec_ic[n];
      for (int k = 0; k < 5; k++) wb(1'b1, ico[k], icv[k], 4'h3);
      rerun();
      rd(DDA_DEC_Y_OFS, icv[4]);
      repeat (40) step(0);
      rd(roo[0], iy);
      rd(roo[1], vx);
      rd(roo[2], vy);
      rd(roo[3], sy);
      rd(roo[4], ey);
      rd(roo[5], ir);
    end
    // Summer connected and every increment weighted by two
    wb(1'b1, DDA_CTRL_OFS, 32'h0000_0012, 4'h1);
    sc = 2;
    son = 1;
    rerun();
    repeat (40) step(0);
    rd(DDA_CTRL_OFS, 32'h0000_0012);
    rd(roo[0], iy);
    rd(roo[1], vx);
    rd(roo[3], sy);
    rd(roo[4], ey);
    sc = 1;
    son = 0;
    // Integrand pushed past full scale with halting enabled
    wb(1'b1, DDA_CTRL_OFS, 1, 4'h1);
    icv[0] = 32767;
    wb(1'b1, DDA_IC_INT_OFS, icv[0], 4'h3);
    {halt, stat} = 5'b1_0000;
    rerun();
    step(0);
    step(1);
    rd(DDA_STAT_OFS, 1);
    chk("overflow", 32'(ovf_o), 32'h0000_0001);
    step(0);
    wb(1'b1, DDA_STAT_OFS, 1, 4'h1);
    stat = 4'h0;
    rd(DDA_STAT_OFS, 0);
    chk("overflow", 32'(ovf_o), 32'h0000_0000);
    close_out();
  end
endmodule
